/* File: core/cd_dsp_pin_level_io.v */
// cd signal processor pin-level io: host command port, servo forward port,
// subcode readout, frame sync status and audio serial data
// assumes i_clk is the crystal clock at 50 MHz; link pins are asynchronous
// Contract
// - clock output at one third of the crystal frequency, high one crystal cycle in three
// - emphasis output high when disc has pre-emphasis, else low
// - subcode sync output high when either subcode sync pattern seen
// - subcode p-w bits shifted out under external readout clock
// - q subcode held as 80-bit word, shifted out serially
// - audio muted while mute input high, released when low
// - device held in reset while reset input low; the logic only stalls, counters and state machines keep their values
// - command word captured at falling edge of command latch
// - forward data to servo processor, word effective at latch fall
// - frame-sync-good high when sync matches insertion timing
// - negative pulse per raw frame sync before protection
// - inverse pll clock output, falling edge at channel transitions
// - read frame clock from crystal, period 136 us
// - jitter overflow output when buffer exceeds four-frame margin
// - error pointer output shows data error status
// - audio data two's complement, msb first
// - monitor output shows frame sync protection state
`timescale 1ns/1ps
`default_nettype none
`include "cd_dsp_pin_level_io_defines.vh"

module cd_dsp_pin_level_io #(
	parameter FRAME_CYCLES = `FRAME_CYCLES
) (
	input  wire                    i_clk,
	input  wire                    i_arst_n,
	input  wire                    i_ce,
	input  wire                    i_system_reset_n,
	input  wire                    i_command_data_in,
	input  wire                    i_command_shift_clock,
	input  wire                    i_command_latch_in,
	input  wire                    i_subcode_pw_read_clock,
	input  wire                    i_subcode_q_read_clock,
	input  wire                    i_mute_in,
	input  wire                    i_pll_clock,
	input  wire                    i_raw_frame_sync,
	input  wire                    i_emphasis_detected,
	input  wire                    i_subcode_sync0,
	input  wire                    i_subcode_sync1,
	input  wire                    i_subcode_block_ready,
	input  wire [`SUBPW_BITS-1:0]  i_subcode_pw_word,
	input  wire [`SUBQ_BITS-1:0]   i_subcode_q_word,
	input  wire                    i_buffer_overflow,
	input  wire                    i_c2_error,
	input  wire                    i_sample_valid,
	input  wire [`SAMPLE_BITS-1:0] i_sample,
	output reg                     o_two_thirds_clock_out,
	output reg                     o_emphasis_flag_out,
	output reg                     o_subcode_sync_out,
	output wire                    o_subcode_pw_serial_out,
	output wire                    o_subcode_q_serial_out,
	output reg  [`CMD_BITS-1:0]    o_command_word,
	output reg                     o_command_valid,
	output reg                     o_servo_data_out,
	output reg                     o_servo_shift_clock_out,
	output reg                     o_servo_latch_out,
	output reg                     o_frame_sync_good,
	output reg                     o_raw_frame_sync_pulse_n,
	output reg                     o_inverted_pll_clock,
	output reg                     o_read_frame_clock,
	output reg                     o_jitter_overflow_n,
	output reg                     o_error_pointer_out,
	output reg                     o_audio_serial_data,
	output reg  [1:0]              o_sync_protection_monitor
);

	// two-stage synchronisers for every asynchronous pin, one bit each
	localparam NSYNC = 14;
	reg  [NSYNC-1:0] meta;
	reg  [NSYNC-1:0] sync;
	reg  [NSYNC-1:0] sync_d;
	wire [NSYNC-1:0] pins;
	assign pins = {i_system_reset_n, i_command_data_in, i_command_shift_clock,
		i_command_latch_in, i_subcode_pw_read_clock, i_subcode_q_read_clock,
		i_mute_in, i_pll_clock, i_raw_frame_sync, i_emphasis_detected,
		i_subcode_sync0, i_subcode_sync1, i_buffer_overflow, i_c2_error};

	wire s_rst_n   = sync[13];
	wire s_data    = sync[12];
	wire s_sclk    = sync[11];
	wire s_latch   = sync[10];
	wire s_pwclk   = sync[9];
	wire s_qclk    = sync[8];
	wire s_mute    = sync[7];
	wire s_pll     = sync[6];
	wire s_fsync   = sync[5];
	wire s_emphasis_flag_out    = sync[4];
	wire s_sync0   = sync[3];
	wire s_sync1   = sync[2];
	wire s_ovf     = sync[1];
	wire s_c2      = sync[0];

	wire sclk_rise  = s_sclk & ~sync_d[11];
	wire latch_fall = ~s_latch & sync_d[10];
	wire pw_rise    = s_pwclk & ~sync_d[9];
	wire q_rise     = s_qclk & ~sync_d[8];
	wire fsync_rise = s_fsync & ~sync_d[5];
	wire run        = i_ce & s_rst_n; // logic stalls while low; counters and state keep their values

	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	// first stage is read only by the second stage; idle levels avoid false edges
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta   <= `SYNC_IDLE;
			sync   <= `SYNC_IDLE;
			sync_d <= `SYNC_IDLE;
		end else if (i_ce) begin
			meta   <= pins;
			sync   <= meta;
			sync_d <= sync;
		end
	end

	// -------------------------------------------------------------
	// two-thirds clock divider
	// -------------------------------------------------------------
	// one output period per three crystal cycles
	reg [1:0] div3;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div3                   <= 2'h0;
			o_two_thirds_clock_out <= 1'b0;
		end else if (run) begin
			div3                   <= (div3 == `DIV3_LAST) ? 2'h0 : div3 + 2'h1;
			o_two_thirds_clock_out <= (div3 < `DIV3_HIGH_LAST) ? 1'b1 : 1'b0;
		end
	end

	// -------------------------------------------------------------
	// read frame clock
	// -------------------------------------------------------------
	// half period high, half low, from the crystal
	reg [`FRAME_CNT_W-1:0] frame_cnt;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			frame_cnt          <= {`FRAME_CNT_W{1'b0}};
			o_read_frame_clock <= 1'b0;
		end else if (run) begin
			if (frame_cnt == FRAME_CYCLES[`FRAME_CNT_W-1:0] - 1'b1) begin
				frame_cnt <= {`FRAME_CNT_W{1'b0}};
			end else begin
				frame_cnt <= frame_cnt + 1'b1;
			end
			o_read_frame_clock <= (frame_cnt < FRAME_CYCLES[`FRAME_CNT_W:1]);
		end
	end

	// -------------------------------------------------------------
	// status flags
	// -------------------------------------------------------------
	// registered copies of the decoder status lines
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_emphasis_flag_out      <= 1'b0;
			o_subcode_sync_out       <= 1'b0;
			o_raw_frame_sync_pulse_n <= 1'b1;
			o_inverted_pll_clock     <= 1'b1;
			o_jitter_overflow_n      <= 1'b1;
			o_error_pointer_out      <= 1'b0;
		end else if (run) begin
			o_emphasis_flag_out      <= s_emphasis_flag_out;
			o_subcode_sync_out       <= s_sync0 | s_sync1;
			o_raw_frame_sync_pulse_n <= ~fsync_rise;
			o_inverted_pll_clock     <= ~s_pll;
			o_jitter_overflow_n      <= ~s_ovf;
			o_error_pointer_out      <= s_c2;
		end else if (i_ce) begin
			o_raw_frame_sync_pulse_n <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// frame sync protection
	// -------------------------------------------------------------
	// syncs within the window of the expected time count as good outside hunt;
	// a missing sync is inserted until too many misses in a row
	reg [1:0]              sp_state;
	reg [2:0]              misses;
	wire [`FRAME_CNT_W-1:0] win = {{(`FRAME_CNT_W-4){1'b0}}, `SP_WINDOW};
	wire expect_near = (frame_cnt < win) ||
		(frame_cnt >= FRAME_CYCLES[`FRAME_CNT_W-1:0] - win);
	wire frame_end   = (frame_cnt == FRAME_CYCLES[`FRAME_CNT_W-1:0] - 1'b1);
	reg  seen;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sp_state          <= `SP_HUNT;
			misses            <= 3'h0;
			seen              <= 1'b0;
			o_frame_sync_good <= 1'b0;
		end else if (run) begin
			if (fsync_rise && expect_near) begin
				seen <= 1'b1;
			end else if (frame_end) begin
				seen <= 1'b0;
			end
			o_frame_sync_good <= fsync_rise & expect_near &
				(sp_state != `SP_HUNT);
			case (sp_state)
				`SP_HUNT: begin
					if (fsync_rise && expect_near) begin
						sp_state <= `SP_LOCKED;
					end
				end
				`SP_LOCKED, `SP_INSERT: begin
					if (frame_end) begin
						if (seen) begin
							sp_state <= `SP_LOCKED;
							misses   <= 3'h0;
						end else if (misses == `SP_MISS_LIMIT) begin
							sp_state <= `SP_HUNT;
							misses   <= 3'h0;
						end else begin
							sp_state <= `SP_INSERT;
							misses   <= misses + 3'h1;
						end
					end
				end
				default: begin
					sp_state <= `SP_HUNT;
				end
			endcase
		end
	end

	always @* begin
		o_sync_protection_monitor = sp_state;
	end

	// -------------------------------------------------------------
	// host command port and servo forward port
	// -------------------------------------------------------------
	// bits shift in on host clock rises; latch fall captures the word
	// and replays it to the servo processor with its own latch
	reg [`CMD_BITS-1:0] cmd_shift;
	reg [`CMD_BITS-1:0] fwd_shift;
	reg [3:0]           fwd_cnt;
	reg                 fwd_busy;
	reg                 fwd_phase;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmd_shift               <= {`CMD_BITS{1'b0}};
			o_command_word          <= {`CMD_BITS{1'b0}};
			o_command_valid         <= 1'b0;
			fwd_shift               <= {`CMD_BITS{1'b0}};
			fwd_cnt                 <= 4'h0;
			fwd_busy                <= 1'b0;
			fwd_phase               <= 1'b0;
			o_servo_data_out        <= 1'b0;
			o_servo_shift_clock_out <= 1'b1;
			o_servo_latch_out       <= 1'b1;
		end else if (run) begin
			o_command_valid <= 1'b0;
			if (sclk_rise) begin
				cmd_shift <= {cmd_shift[`CMD_BITS-2:0], s_data};
			end
			if (latch_fall) begin
				o_command_word  <= cmd_shift;
				o_command_valid <= 1'b1;
				if (!fwd_busy) begin
					fwd_shift <= cmd_shift;
					fwd_busy  <= 1'b1;
					fwd_cnt   <= 4'h0;
					fwd_phase <= 1'b0;
				end
			end else if (fwd_busy) begin
				fwd_phase <= ~fwd_phase;
				if (fwd_cnt < `CMD_BITS) begin
					if (!fwd_phase) begin
						o_servo_shift_clock_out <= 1'b0;
						o_servo_data_out        <= fwd_shift[`CMD_BITS-1];
					end else begin
						o_servo_shift_clock_out <= 1'b1;
						fwd_shift <= {fwd_shift[`CMD_BITS-2:0], 1'b0};
						fwd_cnt   <= fwd_cnt + 4'h1;
					end
				end else if (!fwd_phase) begin
					o_servo_latch_out <= 1'b0; // word takes effect
				end else begin
					o_servo_latch_out <= 1'b1;
					fwd_busy          <= 1'b0;
				end
			end
		end else if (i_ce) begin
			o_command_valid <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// audio serial data
	// -------------------------------------------------------------
	// two's complement sample sent msb first, forced to zero under mute
	reg [`SAMPLE_BITS-1:0] pcm_shift;
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pcm_shift           <= {`SAMPLE_BITS{1'b0}};
			o_audio_serial_data <= 1'b0;
		end else if (run) begin
			if (i_sample_valid) begin
				pcm_shift <= s_mute ? {`SAMPLE_BITS{1'b0}} : i_sample;
			end else begin
				pcm_shift <= {pcm_shift[`SAMPLE_BITS-2:0], 1'b0};
			end
			o_audio_serial_data <= pcm_shift[`SAMPLE_BITS-1];
		end
	end

	// -------------------------------------------------------------
	// subcode readout shifters
	// -------------------------------------------------------------
	// block ready reloads; each read clock rise advances
	serial_shift_out #(
		.WIDTH (`SUBPW_BITS)
	) pw_shifter (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_ce     (run),
		.i_load   (i_subcode_block_ready),
		.i_word   (i_subcode_pw_word),
		.i_shift  (pw_rise),
		.o_bit    (o_subcode_pw_serial_out)
	);

	serial_shift_out #(
		.WIDTH (`SUBQ_BITS)
	) q_shifter (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_ce     (run),
		.i_load   (i_subcode_block_ready),
		.i_word   (i_subcode_q_word),
		.i_shift  (q_rise),
		.o_bit    (o_subcode_q_serial_out)
	);

endmodule
`default_nettype wire

/* File: core/cd_dsp_pin_level_io_defines.vh */
// constants for the cd signal processor pin-level block
// assumes inclusion by bare name from core design files
`ifndef CD_DSP_PIN_LEVEL_IO_DEFINES_VH
`define CD_DSP_PIN_LEVEL_IO_DEFINES_VH

// clock rate and frame period
`define CLK_PERIOD_NS       20
`define FRAME_PERIOD_NS     136000
`define FRAME_CYCLES        (`FRAME_PERIOD_NS / `CLK_PERIOD_NS)
`define FRAME_CNT_W         13

// two-thirds divider: three input cycles per output period
`define DIV3_LAST           2'h2
`define DIV3_HIGH_LAST      2'h1

// synchroniser reset: host clock, latch and readout clocks rest high
`define SYNC_IDLE           14'h0f00

// subcode, command and sample word widths
`define SUBQ_BITS           80
`define SUBPW_BITS          8
`define CMD_BITS            8
`define SAMPLE_BITS         16

// sync protection states, window and miss limit
`define SP_HUNT             2'h0
`define SP_LOCKED           2'h1
`define SP_INSERT           2'h2
`define SP_WINDOW           4'h2
`define SP_MISS_LIMIT       3'h3

`endif

/* File: core/serial_shift_out.v */
// parallel-load serial shifter, msb first, advanced by a synchronised clock
// assumes the read clock is already synchronised to i_clk
`timescale 1ns/1ps
`default_nettype none

module serial_shift_out #(
	parameter WIDTH = 8
) (
	input  wire             i_clk,
	input  wire             i_arst_n,
	input  wire             i_ce,
	input  wire             i_load,
	input  wire [WIDTH-1:0] i_word,
	input  wire             i_shift,
	output wire             o_bit
);

	reg [WIDTH-1:0] shift;

	// -------------------------------------------------------------
	// shift register
	// -------------------------------------------------------------
	// load wins over shift so a fresh block starts at its first bit
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift <= {WIDTH{1'b0}};
		end else if (i_ce) begin
			if (i_load) begin
				shift <= i_word;
			end else if (i_shift) begin
				shift <= {shift[WIDTH-2:0], 1'b0};
			end
		end
	end

	assign o_bit = shift[WIDTH-1]; // msb first

endmodule
`default_nettype wire

/* File: verification/cd_dsp_host_model.sv */
// host command port model: shifts one byte, then latches it
// assumes the block takes bits on shift clock rise, word on latch fall
`timescale 1ns/1ps
`default_nettype none

module cd_dsp_host_model (
	input  wire logic i_clk,
	output var  logic o_data,
	output var  logic o_shift_clock,
	output var  logic o_latch
);
	// ----
	// idle: clock and latch high
	// ----
	initial begin
		o_data = 1'b0;
		o_shift_clock = 1'b1;
		o_latch = 1'b1;
	end

	// one byte msb first, four clocks per phase, then latch pulse
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			repeat (4) @(posedge i_clk);
			#1 o_shift_clock = 1'b0;
			o_data = b[i];
			repeat (4) @(posedge i_clk);
			#1 o_shift_clock = 1'b1;
		end
		repeat (4) @(posedge i_clk);
		#1 o_latch = 1'b0;
		repeat (4) @(posedge i_clk);
		#1 o_latch = 1'b1;
		o_data = ~o_data; // released line shows no stale bit
	endtask
endmodule

`default_nettype wire

/* File: verification/cd_dsp_pin_level_io_sva.sv */
// checker for the pin-level block, watching top-level ports only
// assumes i_ce high and system reset released while checked
`timescale 1ns/1ps
`default_nettype none

module cd_dsp_pin_level_io_sva (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_system_reset_n,
	input wire logic i_command_latch_in,
	input wire logic i_emphasis_detected,
	input wire logic i_subcode_sync0,
	input wire logic i_subcode_sync1,
	input wire logic i_buffer_overflow,
	input wire logic i_c2_error,
	input wire logic i_pll_clock,
	input wire logic i_raw_frame_sync,
	input wire logic o_two_thirds_clock_out,
	input wire logic o_emphasis_flag_out,
	input wire logic o_subcode_sync_out,
	input wire logic o_command_valid,
	input wire logic o_servo_latch_out,
	input wire logic o_raw_frame_sync_pulse_n,
	input wire logic o_jitter_overflow_n,
	input wire logic o_error_pointer_out,
	input wire logic o_inverted_pll_clock,
	input wire logic o_frame_sync_good
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n || !i_ce || !i_system_reset_n);

	// ----
	// steps of the divider and latch sequences
	// ----
	sequence s_div_rest;
		!o_two_thirds_clock_out [*2] ##1 o_two_thirds_clock_out;
	endsequence
	sequence s_latch_fall;
		$fell(i_command_latch_in);
	endsequence

	a_div_three: assert property ($rose(o_two_thirds_clock_out) |=> s_div_rest)
		else $error("divider period wrong");
	a_emphasis_flag_out_follows: assert property (
		$rose(i_emphasis_detected) |-> ##[2:4] o_emphasis_flag_out)
		else $error("emphasis flag late");
	a_subcode_sync_out_either: assert property (
		$rose(i_subcode_sync0 | i_subcode_sync1) |-> ##[2:4] o_subcode_sync_out)
		else $error("subcode sync late");
	a_cmd_latched: assert property (s_latch_fall |-> ##[3:5] o_command_valid)
		else $error("command not captured");
	a_valid_one: assert property (o_command_valid |=> !o_command_valid)
		else $error("valid too long");
	a_servo_latch: assert property ($fell(o_servo_latch_out) |=> o_servo_latch_out)
		else $error("servo latch width wrong");
	a_good_pulse: assert property (o_frame_sync_good |=> !o_frame_sync_good)
		else $error("frame sync good too long");
	a_raw_pulse: assert property (
		$rose(i_raw_frame_sync) |->
		##[2:4] $fell(o_raw_frame_sync_pulse_n) ##1 o_raw_frame_sync_pulse_n)
		else $error("raw sync pulse wrong");
	a_pll_inverse: assert property (
		$rose(i_pll_clock) |-> ##[2:4] $fell(o_inverted_pll_clock))
		else $error("pll clock not inverted");
	a_overflow_low: assert property (
		$rose(i_buffer_overflow) |-> ##[2:4] !o_jitter_overflow_n)
		else $error("overflow not flagged");
	a_error_ptr: assert property (
		$rose(i_c2_error) |-> ##[2:4] o_error_pointer_out)
		else $error("error pointer late");
endmodule

bind cd_dsp_pin_level_io cd_dsp_pin_level_io_sva u_sva (.*);

`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the pin-level block with a host model
// assumes the design header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "cd_dsp_pin_level_io_defines.vh"

module testbench;
	localparam int FC = 40;
	logic i_clk, i_arst_n, i_system_reset_n, i_mute_in, i_pll_clock, i_raw_frame_sync;
	logic i_subcode_pw_read_clock, i_subcode_q_read_clock, i_emphasis_detected;
	logic i_subcode_sync0, i_subcode_sync1, i_subcode_block_ready, i_buffer_overflow;
	logic i_c2_error, i_sample_valid, i_ce;
	logic [`SUBPW_BITS-1:0] i_subcode_pw_word;
	logic [`SUBQ_BITS-1:0]  i_subcode_q_word;
	logic [`SAMPLE_BITS-1:0] i_sample;
	wire logic i_command_data_in, i_command_shift_clock, i_command_latch_in;
	wire logic o_two_thirds_clock_out, o_emphasis_flag_out, o_subcode_sync_out;
	wire logic o_subcode_pw_serial_out, o_subcode_q_serial_out, o_command_valid;
	wire logic o_servo_data_out, o_servo_shift_clock_out, o_servo_latch_out;
	wire logic o_frame_sync_good, o_raw_frame_sync_pulse_n, o_inverted_pll_clock;
	wire logic o_read_frame_clock, o_jitter_overflow_n, o_error_pointer_out;
	wire logic o_audio_serial_data;
	wire logic [`CMD_BITS-1:0] o_command_word;
	wire logic [1:0] o_sync_protection_monitor, clk_outs;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [7:0] sv, fwd;

	assign clk_outs = {o_read_frame_clock, o_two_thirds_clock_out};
	cd_dsp_pin_level_io #(.FRAME_CYCLES(FC)) DUT (.*);
	cd_dsp_host_model host (.i_clk(i_clk), .o_data(i_command_data_in),
		.o_shift_clock(i_command_shift_clock), .o_latch(i_command_latch_in));

	// ----
	// clock, servo port capture, watchdog
	// ----
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge o_servo_shift_clock_out) sv <= {sv[6:0], o_servo_data_out};
	always @(negedge o_servo_latch_out) fwd = sv;
	initial begin
		#200_000 n_mismatch++;
		summarize();
	end

	task automatic summarize();
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [79:0] g, input logic [79:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// high time and rise-to-rise period of one clock output
	task automatic period(input int k, output int h, output int p);
		int n;
		n = 0;
		while (clk_outs[k] !== 1'b0 && n < 200) begin @(posedge i_clk); #1 n++; end
		while (clk_outs[k] !== 1'b1 && n < 400) begin @(posedge i_clk); #1 n++; end
		h = 0;
		while (clk_outs[k] === 1'b1 && h < 200) begin @(posedge i_clk); #1 h++; end
		p = h;
		while (clk_outs[k] !== 1'b1 && p < 200) begin @(posedge i_clk); #1 p++; end
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_clocks();
		int h, p;
		period(0, h, p);
		chk(h, 1);
		chk(p, 3);
		period(1, h, p);
		chk(p, FC);
	endtask
	task automatic t_levels();
		logic [5:0] lv;
		for (int i = 0; i < 7; i++) begin
			lv = (i < 6) ? 6'h01 << i : 6'h00;
			@(posedge i_clk); #1;
			{i_emphasis_detected, i_c2_error, i_subcode_sync0, i_subcode_sync1,
				i_buffer_overflow, i_pll_clock} = lv;
			repeat (8) @(posedge i_clk); #1;
			chk({o_emphasis_flag_out, o_error_pointer_out}, lv[5:4]);
			chk({o_subcode_sync_out, !o_jitter_overflow_n, !o_inverted_pll_clock},
				{lv[3] | lv[2], lv[1:0]});
		end
	endtask
	task automatic t_raw();
		int lo;
		lo = 0;
		@(posedge i_clk); #1 i_raw_frame_sync = 1'b1;
		for (int k = 0; k < 12; k++) begin
			@(posedge i_clk); #1;
			if (k == 3) i_raw_frame_sync = 1'b0;
			lo += (o_raw_frame_sync_pulse_n === 1'b0);
		end
		chk(lo, 1);
	endtask
	task automatic t_command(input logic [7:0] b, input logic en);
		logic seen;
		seen = 1'b0;
		fork
			host.send(b);
			repeat (120) begin @(posedge i_clk); #2 if (o_command_valid === 1'b1) seen = 1'b1; end
		join
		chk(seen, en);
		if (en) chk(o_command_word, b);
		if (en) chk(fwd, b);
	endtask
	task automatic t_subcode();
		@(posedge i_clk); #1;
		i_subcode_q_word = 80'h0123_4567_89ab_cdef_5a3c;
		i_subcode_pw_word = 8'hc9;
		i_subcode_block_ready = 1'b1;
		@(posedge i_clk); #1 i_subcode_block_ready = 1'b0;
		@(posedge i_clk); #1;
		for (int i = 0; i < 80; i++) begin
			chk(o_subcode_q_serial_out, i_subcode_q_word[79-i]);
			if (i < 8) chk(o_subcode_pw_serial_out, i_subcode_pw_word[7-i]);
			i_subcode_q_read_clock = 1'b0;
			i_subcode_pw_read_clock = (i >= 8);
			repeat (4) @(posedge i_clk); #1;
			{i_subcode_q_read_clock, i_subcode_pw_read_clock} = 2'h3;
			repeat (5) @(posedge i_clk); #1;
		end
	endtask
	task automatic t_audio(input logic [15:0] s, input logic m);
		@(posedge i_clk); #1 i_mute_in = m;
		repeat (4) @(posedge i_clk); #1;
		i_sample = s;
		i_sample_valid = 1'b1;
		@(posedge i_clk); #1 i_sample_valid = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge i_clk); #1;
			chk(o_audio_serial_data, m ? 1'b0 : s[i]);
		end
	endtask
	// raw syncs two cycles before frame end lock, missing syncs fall back to hunt
	task automatic t_sync();
		int good;
		good = 0;
		@(posedge o_read_frame_clock); #1;
		for (int f = 0; f < 3; f++) begin
			repeat (FC - 5) @(posedge i_clk); #1 i_raw_frame_sync = 1'b1;
			repeat (3) @(posedge i_clk); #1 good += (o_frame_sync_good === 1'b1);
			repeat (2) @(posedge i_clk); #1 i_raw_frame_sync = 1'b0;
		end
		chk(good, 2);
		chk(o_sync_protection_monitor, `SP_LOCKED);
		repeat (FC) @(posedge i_clk); #1;
		chk(o_sync_protection_monitor, `SP_INSERT);
		repeat (3 * FC) @(posedge i_clk); #1;
		chk(o_sync_protection_monitor, `SP_HUNT);
	endtask
	// clock enable low freezes the clock outputs
	task automatic t_freeze();
		logic [1:0] held;
		@(posedge i_clk); #1 i_ce = 1'b0;
		held = clk_outs;
		repeat (6) @(posedge i_clk); #1;
		chk(clk_outs, held);
		i_ce = 1'b1;
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		{i_mute_in, i_pll_clock, i_raw_frame_sync, i_emphasis_detected, i_subcode_sync0,
			i_subcode_sync1, i_subcode_block_ready, i_buffer_overflow, i_c2_error,
			i_sample_valid, i_arst_n} = '0;
		{i_subcode_pw_read_clock, i_subcode_q_read_clock, i_system_reset_n, i_ce} = 4'hf;
		i_subcode_pw_word = '0;
		i_subcode_q_word = '0;
		i_sample = '0;
		repeat (8) @(posedge i_clk);
		#1 i_arst_n = 1'b1;
		repeat (4) @(posedge i_clk);
		#1 chk(o_sync_protection_monitor, `SP_HUNT);
		t_clocks();
		t_sync();
		t_levels();
		t_freeze();
		t_raw();
		t_command(8'ha5, 1'b1);
		t_subcode();
		t_audio(16'h8001, 1'b0);
		t_audio(16'hffff, 1'b1);
		t_audio(16'h7ffe, 1'b0);
		i_system_reset_n = 1'b0;
		t_command(8'h3c, 1'b0);
		summarize();
	end
endmodule

`default_nettype wire
